// ===== mpqr_top.sv
`include "mpqr_cfg.svh"
`default_nettype none

// What this block does
// RULE_01 - sdram pins stay idle after reset until software enables sdram
// RULE_02 - boot rom settings come from boot strap pins sampled in reset
// RULE_03 - boot rom reads are answered right after reset release
// RULE_04 - configuration writes are accepted as soon as reset releases
// RULE_05 - reset and every low-power mode apply one fixed pin set
// RULE_06 - sdram clocks, clock enable and byte masks driven low there
// RULE_07 - upper sdram selects driven high when owned by the controller
// RULE_08 - five upper static selects driven high there
// RULE_09 - card io and memory strobes driven high there
// RULE_10 - shared pins show controller value only when alternate selected
// RULE_11 - low power: address driven zero, data bus released, pulled low
// RULE_12 - other control outputs take their after-reset value
// RULE_13 - clock enable held low while sdram sits in self-refresh
// RULE_14 - direction low; write, row, column, output strobes held high

module mpqr_top
    import mpqr_pkg::*;
#(
    parameter int ADDR_W = 26,
    parameter int DATA_W = 32,
    parameter int CLK_W  = 3,
    parameter int MASK_W = 4,
    parameter int BOOT_W = 3
) (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    // power manager requests
    input  wire logic                lp_sleep,
    input  wire logic                lp_standby,
    input  wire logic                lp_deep_sleep,
    input  wire logic                lp_freq_change,
    input  wire logic                lp_self_refresh,
    input  wire logic                sdram_in_self_refresh,
    // boot strap pins
    input  wire logic [BOOT_W-1:0]   boot_sel_pin,
    output logic      [BOOT_W-1:0]   boot_rom_cfg,
    // configuration write port
    input  wire logic                cfg_wr_valid,
    input  wire logic [31:0]         cfg_wr_data,
    output logic                     cfg_wr_ready,
    output logic                     sdram_enabled,
    // boot rom read handshake
    input  wire logic                rom_rd_valid,
    output logic                     rom_rd_ready,
    // functional values from the command sequencer
    input  wire logic [CLK_W-1:0]    func_clock_out,
    input  wire logic                func_clock_enable,
    input  wire logic [MASK_W-1:0]   func_byte_mask,
    input  wire logic [3:0]          func_sdram_cs_n,
    input  wire logic                func_write_n,
    input  wire logic                func_row_n,
    input  wire logic                func_column_n,
    input  wire logic                func_oe_n,
    input  wire logic [ADDR_W-1:0]   func_address,
    input  wire logic                func_direction,
    input  wire logic [DATA_W-1:0]   func_data,
    input  wire logic                func_data_oe,
    input  wire logic [5:0]          func_static_cs_n,
    input  wire logic [3:0]          func_card_n,
    // gpio side of shared pins
    input  wire logic [10:0]         gpio_alt_sel,
    input  wire logic [10:0]         gpio_out_val,
    // memory pins
    output logic [CLK_W-1:0]         sdram_clock_out,
    output logic                     sdram_clock_enable,
    output logic [MASK_W-1:0]        sdram_byte_mask,
    output logic [3:0]               sdram_chip_select_n,
    output logic                     write_strobe_n,
    output logic                     row_strobe_n,
    output logic                     column_strobe_n,
    output logic                     output_enable_n,
    output logic [ADDR_W-1:0]        memory_address_bus,
    output logic                     read_write_direction,
    input  wire logic [DATA_W-1:0]   memory_data_bus_i,
    output logic [DATA_W-1:0]        memory_data_bus_o,
    output logic                     memory_data_bus_oe,
    output logic                     memory_data_pull_low,
    output logic [5:0]               static_chip_select_n,
    output logic                     card_io_read_n,
    output logic                     card_io_write_n,
    output logic                     card_mem_read_n,
    output logic                     card_mem_write_n,
    output logic [DATA_W-1:0]        read_data
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < 1 || ADDR_W > 32) begin : g_chk_addr
        $error("address width out of range");
    end
    if (DATA_W % 8 != 0 || MASK_W != DATA_W / 8) begin : g_chk_data
        $error("byte mask width must match data width");
    end
    if (CLK_W < 1 || BOOT_W < 1) begin : g_chk_misc
        $error("clock and strap widths must be nonzero");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    mpqr_state_t          state_r;
    mpqr_state_t          state_nxt;
    logic                 lp_any;
    logic                 sdram_en_r;
    logic [BOOT_W-1:0]    boot_s1_r;
    logic [BOOT_W-1:0]    boot_s2_r;
    logic [BOOT_W-1:0]    boot_cfg_r;
    logic [DATA_W-1:0]    rd_data_r;
    logic [DATA_W-1:0]    data_s1_r;
    logic [DATA_W-1:0]    data_s2_r;
    logic                 sd_live;
    logic                 mem_live;
    logic [CLK_W-1:0]     clk_out_r;
    logic                 cke_r;
    logic [MASK_W-1:0]    mask_r;
    logic [1:0]           sdcs_lo_r;
    logic                 we_r;
    logic                 ras_r;
    logic                 cas_r;
    logic                 oe_r;
    logic [ADDR_W-1:0]    addr_r;
    logic                 dir_r;
    logic [DATA_W-1:0]    dout_r;
    logic                 doe_r;
    logic                 pull_r;
    logic                 cs0_r;
    logic [`MPQR_SH_W-1:0] sh_ctrl;

    mpqr_shared_if #(.W(`MPQR_SH_W)) sh_if ();

    assign lp_any = lp_sleep | lp_standby | lp_deep_sleep
                  | lp_freq_change | lp_self_refresh;

    // ------------------------------------------------------------
    // pin state machine
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MPQR_ST_HOLD: begin
                if (lp_any) begin
                    state_nxt = MPQR_ST_QUIET;                  // [RULE_05]
                end else if (sdram_en_r) begin
                    state_nxt = MPQR_ST_RUN;
                end
            end
            MPQR_ST_RUN: begin
                if (lp_any) begin
                    state_nxt = MPQR_ST_QUIET;                  // [RULE_05]
                end else if (!sdram_en_r) begin
                    state_nxt = MPQR_ST_HOLD;
                end
            end
            MPQR_ST_QUIET: begin
                if (!lp_any) begin
                    state_nxt = sdram_en_r ? MPQR_ST_RUN : MPQR_ST_HOLD;
                end
            end
            default: begin
                state_nxt = MPQR_ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_r <= MPQR_ST_HOLD;                            // [RULE_01]
        end else begin
            state_r <= state_nxt;
        end
    end

    // sdram pins only live when enabled; memory pins live out of low power
    assign sd_live  = resetn && state_r == MPQR_ST_RUN && !lp_any;
    assign mem_live = resetn && state_r != MPQR_ST_QUIET && !lp_any;

    // ------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sdram_en_r <= `MPQR_CFG_EN_RST;                     // [RULE_01]
        end else if (cfg_wr_valid) begin
            sdram_en_r <= cfg_wr_data[`MPQR_CFG_EN_BIT];        // [RULE_04]
        end
    end

    // writes need no prior setup, so ready follows reset alone
    assign cfg_wr_ready  = resetn;                              // [RULE_04]
    assign sdram_enabled = sdram_en_r;

    // ------------------------------------------------------------
    // boot strap capture
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        boot_s1_r <= boot_sel_pin;
        boot_s2_r <= boot_s1_r;
    end

    // strap is tracked while reset is held and frozen at release
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            boot_cfg_r <= boot_s2_r;                            // [RULE_02]
        end
    end

    assign boot_rom_cfg = boot_cfg_r;

    // ------------------------------------------------------------
    // boot rom read path
    // ------------------------------------------------------------
    // rom sits on static select 0, which needs no configuration
    assign rom_rd_ready = mem_live;                             // [RULE_03]

    always_ff @(posedge ref_clk) begin
        data_s1_r <= memory_data_bus_i;
        data_s2_r <= data_s1_r;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rd_data_r <= {DATA_W{`MPQR_DATA_IDLE}};
        end else if (rom_rd_valid && mem_live) begin
            rd_data_r <= data_s2_r;                             // [RULE_03]
        end
    end

    assign read_data = rd_data_r;

    // ------------------------------------------------------------
    // sdram pins
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!sd_live) begin
            clk_out_r <= {CLK_W{`MPQR_CLK_IDLE}};               // [RULE_06]
            mask_r    <= {MASK_W{`MPQR_MASK_IDLE}};             // [RULE_06]
            sdcs_lo_r <= {2{`MPQR_SEL_IDLE}};                   // [RULE_12]
            ras_r     <= `MPQR_STROBE_IDLE;                     // [RULE_14]
            cas_r     <= `MPQR_STROBE_IDLE;                     // [RULE_14]
        end else begin
            clk_out_r <= func_clock_out;
            mask_r    <= func_byte_mask;
            sdcs_lo_r <= func_sdram_cs_n[1:0];
            ras_r     <= func_row_n;
            cas_r     <= func_column_n;
        end
    end

    // self-refresh overrides even a live interface
    always_ff @(posedge ref_clk) begin
        if (!sd_live || sdram_in_self_refresh) begin
            cke_r <= `MPQR_CKE_IDLE;                            // [RULE_06] [RULE_13]
        end else begin
            cke_r <= func_clock_enable;
        end
    end

    // ------------------------------------------------------------
    // static memory pins
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!mem_live) begin
            we_r   <= `MPQR_STROBE_IDLE;                        // [RULE_14]
            oe_r   <= `MPQR_STROBE_IDLE;                        // [RULE_14]
            dir_r  <= `MPQR_DIR_IDLE;                           // [RULE_14]
            cs0_r  <= `MPQR_SEL_IDLE;                           // [RULE_12]
            addr_r <= {ADDR_W{`MPQR_ADDR_IDLE}};                // [RULE_11]
        end else begin
            we_r   <= func_write_n;
            oe_r   <= func_oe_n;
            dir_r  <= func_direction;
            cs0_r  <= func_static_cs_n[0];
            addr_r <= func_address;
        end
    end

    // ------------------------------------------------------------
    // data bus: released and pulled low, never driven, when quiet
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!mem_live) begin
            dout_r <= {DATA_W{`MPQR_DATA_IDLE}};
            doe_r  <= 1'h0;                                     // [RULE_11]
            pull_r <= 1'h1;                                     // [RULE_11]
        end else begin
            dout_r <= func_data;
            doe_r  <= func_data_oe;
            pull_r <= 1'h0;
        end
    end

    // ------------------------------------------------------------
    // shared pins
    // ------------------------------------------------------------
    // ctrl values are forced idle unless their interface is live; the mux picks owner per pin
    always_comb begin
        sh_ctrl = {`MPQR_SH_W{`MPQR_SEL_IDLE}};                 // [RULE_07] [RULE_08] [RULE_09]
        if (mem_live) begin
            sh_ctrl[`MPQR_SH_CS_LO +: 5]   = func_static_cs_n[5:1];
            sh_ctrl[`MPQR_SH_CARD_LO +: 4] = func_card_n;
        end
        if (sd_live) begin
            sh_ctrl[`MPQR_SH_SDCS_LO +: 2] = func_sdram_cs_n[3:2];
        end
    end

    assign sh_if.ctrl_val = sh_ctrl;
    assign sh_if.gpio_val = gpio_out_val;
    assign sh_if.alt_sel  = gpio_alt_sel;

    mpqr_pin_mux #(
        .W (`MPQR_SH_W)
    ) u_pin_mux (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .sh      (sh_if.mux)                                    // [RULE_10]
    );

    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------
    assign sdram_clock_out      = clk_out_r;
    assign sdram_clock_enable   = cke_r;
    assign sdram_byte_mask      = mask_r;
    assign sdram_chip_select_n  = {sh_if.pin_val[`MPQR_SH_SDCS_LO +: 2],
                                   sdcs_lo_r};
    assign write_strobe_n       = we_r;
    assign row_strobe_n         = ras_r;
    assign column_strobe_n      = cas_r;
    assign output_enable_n      = oe_r;
    assign memory_address_bus   = addr_r;
    assign read_write_direction = dir_r;
    assign memory_data_bus_o    = dout_r;
    assign memory_data_bus_oe   = doe_r;
    assign memory_data_pull_low = pull_r;
    assign static_chip_select_n = {sh_if.pin_val[`MPQR_SH_CS_LO +: 5],
                                   cs0_r};
    assign card_io_read_n       = sh_if.pin_val[`MPQR_SH_CARD_LO];
    assign card_io_write_n      = sh_if.pin_val[`MPQR_SH_CARD_LO + 1];
    assign card_mem_read_n      = sh_if.pin_val[`MPQR_SH_CARD_LO + 2];
    assign card_mem_write_n     = sh_if.pin_val[`MPQR_SH_CARD_LO + 3];

endmodule

`default_nettype wire

// ===== mpqr_cfg.svh
`ifndef MPQR_CFG_SVH
`define MPQR_CFG_SVH

// ------------------------------------------------------------
// idle pin levels held in reset and in every low-power mode
// ------------------------------------------------------------
`define MPQR_CLK_IDLE      1'h0
`define MPQR_CKE_IDLE      1'h0
`define MPQR_MASK_IDLE     1'h0
`define MPQR_SEL_IDLE      1'h1
`define MPQR_STROBE_IDLE   1'h1
`define MPQR_DIR_IDLE      1'h0
`define MPQR_ADDR_IDLE     1'h0
`define MPQR_DATA_IDLE     1'h0

// ------------------------------------------------------------
// configuration word layout and reset values
// ------------------------------------------------------------
`define MPQR_CFG_EN_BIT    0
`define MPQR_CFG_EN_RST    1'h0

// ------------------------------------------------------------
// shared pin group layout
// ------------------------------------------------------------
`define MPQR_SH_SDCS_LO    0
`define MPQR_SH_CS_LO      2
`define MPQR_SH_CARD_LO    7
`define MPQR_SH_W          11

`endif

// ===== mpqr_pkg.sv
`default_nettype none

package mpqr_pkg;

    // ------------------------------------------------------------
    // controller pin state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MPQR_ST_HOLD  = 3'b001,
        MPQR_ST_RUN   = 3'b010,
        MPQR_ST_QUIET = 3'b100
    } mpqr_state_t;

endpackage

`default_nettype wire

// ===== mpqr_shared_if.sv
`default_nettype none

interface mpqr_shared_if #(
    parameter int W = 11
);
    logic [W-1:0] ctrl_val;
    logic [W-1:0] gpio_val;
    logic [W-1:0] alt_sel;
    logic [W-1:0] pin_val;

    modport core (
        output ctrl_val,
        output gpio_val,
        output alt_sel,
        input  pin_val
    );

    modport mux (
        input  ctrl_val,
        input  gpio_val,
        input  alt_sel,
        output pin_val
    );
endinterface

`default_nettype wire

// ===== mpqr_pin_mux.sv
`include "mpqr_cfg.svh"
`default_nettype none

module mpqr_pin_mux #(
    parameter int W = 11
) (
    input  wire logic    ref_clk,
    input  wire logic    resetn,
    mpqr_shared_if.mux   sh
);
    logic [W-1:0] pin_r;

    // ------------------------------------------------------------
    // per-pin owner select, registered so pins never glitch
    // ------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_pin
        always_ff @(posedge ref_clk) begin
            if (!resetn) begin
                // alt owner keeps deselect level in reset [RULE_10]
                pin_r[i] <= sh.alt_sel[i] ? `MPQR_SEL_IDLE
                                          : sh.gpio_val[i];
            end else begin
                pin_r[i] <= sh.alt_sel[i] ? sh.ctrl_val[i]
                                          : sh.gpio_val[i]; // [RULE_10]
            end
        end
    end

    assign sh.pin_val = pin_r;

endmodule

`default_nettype wire

// ===== mpqr_top_sva.sv
`default_nettype none

module mpqr_top_sva #(
    parameter int ADDR_W = 26,
    parameter int CLK_W  = 3,
    parameter int BOOT_W = 3
) (
    input wire logic              ref_clk,
    input wire logic              resetn,
    input wire logic              lp_sleep,
    input wire logic              lp_standby,
    input wire logic              lp_deep_sleep,
    input wire logic              lp_freq_change,
    input wire logic              lp_self_refresh,
    input wire logic              sdram_in_self_refresh,
    input wire logic [BOOT_W-1:0] boot_rom_cfg,
    input wire logic              cfg_wr_valid,
    input wire logic [31:0]       cfg_wr_data,
    input wire logic              cfg_wr_ready,
    input wire logic              sdram_enabled,
    input wire logic              rom_rd_ready,
    input wire logic [10:0]       gpio_alt_sel,
    input wire logic [10:0]       gpio_out_val,
    input wire logic [CLK_W-1:0]  sdram_clock_out,
    input wire logic              sdram_clock_enable,
    input wire logic [3:0]        sdram_chip_select_n,
    input wire logic              write_strobe_n,
    input wire logic              row_strobe_n,
    input wire logic              output_enable_n,
    input wire logic [ADDR_W-1:0] memory_address_bus,
    input wire logic              read_write_direction,
    input wire logic              memory_data_bus_oe,
    input wire logic              memory_data_pull_low,
    input wire logic [5:0]        static_chip_select_n,
    input wire logic              card_io_read_n,
    input wire logic              card_mem_write_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // ---
    // low-power entry, then gpio, self-refresh, config, disable, rom and strap checks
    // ---
    wire logic lp_any = lp_sleep | lp_standby | lp_deep_sleep
                        | lp_freq_change | lp_self_refresh;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    property p_lp_clk; lp_any |=> sdram_clock_out == '0; endproperty
    a_lp_clk: assert property (p_lp_clk) else $error("clock");
    property p_lp_sel; lp_any |=> sdram_chip_select_n == {$past(
        gpio_alt_sel[1:0] | gpio_out_val[1:0]), 2'h3}; endproperty
    a_lp_sel: assert property (p_lp_sel) else $error("sd sel");
    property p_lp_cs; lp_any |=> static_chip_select_n == {$past(
        gpio_alt_sel[6:2] | gpio_out_val[6:2]), 1'h1}; endproperty
    a_lp_cs: assert property (p_lp_cs) else $error("cs");
    property p_lp_card; lp_any |=> {card_mem_write_n, card_io_read_n} ==
        $past({gpio_alt_sel[10] | gpio_out_val[10],
               gpio_alt_sel[7] | gpio_out_val[7]}); endproperty
    a_lp_card: assert property (p_lp_card) else $error("card");
    property p_lp_addr; lp_any |=> memory_address_bus == '0
        && !memory_data_bus_oe && memory_data_pull_low; endproperty
    a_lp_addr: assert property (p_lp_addr) else $error("addr");
    property p_lp_strb; lp_any |=> write_strobe_n && row_strobe_n
        && output_enable_n && !read_write_direction; endproperty
    a_lp_strb: assert property (p_lp_strb) else $error("strb");
    property p_gpio; 1'h1 |=> (static_chip_select_n[5:1]
        & ~$past(gpio_alt_sel[6:2]))
        == $past(gpio_out_val[6:2] & ~gpio_alt_sel[6:2]); endproperty
    a_gpio: assert property (p_gpio) else $error("gpio pin");
    property p_sr; sdram_in_self_refresh |=> !sdram_clock_enable; endproperty
    a_sr: assert property (p_sr) else $error("cke");
    property p_cfg; cfg_wr_valid |-> cfg_wr_ready
        ##1 sdram_enabled == $past(cfg_wr_data[0]); endproperty
    a_cfg: assert property (p_cfg) else $error("cfg write");
    property p_dis; !sdram_enabled [*2] |=> sdram_clock_out == '0
        && row_strobe_n && !sdram_clock_enable; endproperty
    a_dis: assert property (p_dis) else $error("sd on");
    property p_rom; $rose(resetn) && !lp_any |-> rom_rd_ready; endproperty
    a_rom: assert property (p_rom) else $error("rom");
    property p_boot; resetn && $past(resetn) |-> $stable(boot_rom_cfg);
    endproperty
    a_boot: assert property (p_boot) else $error("boot");
endmodule

bind mpqr_top mpqr_top_sva #(.ADDR_W(ADDR_W), .CLK_W(CLK_W),
    .BOOT_W(BOOT_W)) u_mpqr_top_sva (.*);

`default_nettype wire

// ===== mpqr_mem_model.sv
`default_nettype none

module mpqr_mem_model #(
    parameter int ADDR_W = 26,
    parameter int DATA_W = 32
) (
    input  wire logic              ref_clk,
    input  wire logic [ADDR_W-1:0] memory_address_bus,
    input  wire logic              output_enable_n,
    input  wire logic              memory_data_bus_oe,
    input  wire logic [DATA_W-1:0] memory_data_bus_o,
    input  wire logic              memory_data_pull_low,
    output logic      [DATA_W-1:0] memory_data_bus_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // ---
    // resolved data wire
    // ---
    logic [DATA_W-1:0] last_r;

    always @(posedge ref_clk) last_r <= memory_data_bus_i;

    assign memory_data_bus_i = memory_data_bus_oe ? memory_data_bus_o
        : !output_enable_n ? DATA_W'(memory_address_bus) ^ 32'h3c5a_96e1
        : memory_data_pull_low ? '0
        : ~last_r;
endmodule

`default_nettype wire

// ===== mpqr_tb_top.sv
`default_nettype none

module mpqr_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk, resetn, sdram_in_self_refresh;
    logic        lp_sleep, lp_standby, lp_deep_sleep, lp_freq_change;
    logic        lp_self_refresh, cfg_wr_valid, cfg_wr_ready;
    logic        sdram_enabled, rom_rd_valid, rom_rd_ready;
    logic        func_clock_enable, func_write_n, func_row_n;
    logic        func_column_n, func_oe_n, func_direction, func_data_oe;
    logic        sdram_clock_enable, write_strobe_n, row_strobe_n;
    logic        column_strobe_n, output_enable_n, read_write_direction;
    logic        memory_data_bus_oe, memory_data_pull_low;
    logic        card_io_read_n, card_io_write_n;
    logic        card_mem_read_n, card_mem_write_n;
    logic [2:0]  boot_sel_pin, boot_rom_cfg, boot_exp;
    logic [2:0]  func_clock_out, sdram_clock_out;
    logic [3:0]  func_byte_mask, func_sdram_cs_n, func_card_n;
    logic [3:0]  sdram_byte_mask, sdram_chip_select_n;
    logic [5:0]  func_static_cs_n, static_chip_select_n;
    logic [10:0] gpio_alt_sel, gpio_out_val, gh;
    logic [25:0] func_address, memory_address_bus;
    logic [31:0] cfg_wr_data, func_data, memory_data_bus_i;
    logic [31:0] memory_data_bus_o, read_data, h1, h2, h3;
    logic [31:0] seed = 32'h8cd6_e4ed;
    int          error_cnt = 0;
    int          check_count = 0;

    mpqr_top u_mpqr_top (.*);
    mpqr_mem_model u_mpqr_mem_model (.*);
    assign gh = gpio_alt_sel | gpio_out_val;

    // ---
    // helpers
    // ---
    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        h3 <= h2;
        h2 <= h1;
        h1 <= memory_data_bus_i;
    end

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function logic [10:0] got_sh();
        return {card_mem_write_n, card_mem_read_n, card_io_write_n,
                card_io_read_n, static_chip_select_n[5:1],
                sdram_chip_select_n[3:2]};
    endfunction

    task chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task lp(input logic [4:0] v);
        {lp_self_refresh, lp_freq_change, lp_deep_sleep, lp_standby,
         lp_sleep} = v;
    endtask
    task shuffle();
        {func_clock_out, func_clock_enable, func_byte_mask,
         func_sdram_cs_n} = 12'(rnd());
        {func_write_n, func_row_n, func_column_n, func_oe_n, func_direction,
         func_data_oe, func_static_cs_n, func_card_n} = 16'(rnd());
        func_address = 26'(rnd());
        func_data = rnd();
        {gpio_alt_sel, gpio_out_val} = 22'(rnd());
    endtask
    task chk_sd();
        chk({sdram_clock_out, sdram_clock_enable, sdram_byte_mask,
            sdram_chip_select_n[1:0], row_strobe_n, column_strobe_n},
            12'h00f);
    endtask
    task chk_idle();
        chk({sdram_clock_out, sdram_clock_enable, sdram_byte_mask},
            0);
        chk(sdram_chip_select_n, {gh[1:0], 2'h3});
        chk(static_chip_select_n, {gh[6:2], 1'h1});
        chk(got_sh() >> 7, gh >> 7);
        chk({write_strobe_n, row_strobe_n, column_strobe_n, output_enable_n,
            read_write_direction}, 5'h1e);
        chk({memory_address_bus, memory_data_bus_oe, memory_data_pull_low},
            1'h1);
    endtask
    task chk_run();
        chk({sdram_clock_out, memory_address_bus, sdram_clock_enable},
            {func_clock_out, func_address, func_clock_enable});
        chk({row_strobe_n, write_strobe_n},
            {func_row_n, func_write_n});
        chk(got_sh() & ~gpio_alt_sel, gpio_out_val & ~gpio_alt_sel);
    endtask
    task wr(input logic [31:0] d);
        cfg_wr_valid = 1'h1;
        cfg_wr_data = d;
        cyc(1);
        chk(sdram_enabled, d[0]);
    endtask
    task give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge ref_clk);
        error_cnt++;
        give_verdict();
    end

    // ---
    // scenarios
    // ---
    initial begin
        lp(5'h00);
        sdram_in_self_refresh = 1'h0;
        {cfg_wr_valid, rom_rd_valid, resetn} = 3'h0;
        cfg_wr_data = '0;
        boot_exp = 3'(rnd());
        boot_sel_pin = boot_exp;
        shuffle();
        cyc(3);
        chk_idle();
        resetn = 1'h1;
        rom_rd_valid = 1'h1;
        cfg_wr_valid = 1'h1;
        #1;
        chk({rom_rd_ready, cfg_wr_ready}, 2'h3);
        cyc(1);
        {cfg_wr_valid, rom_rd_valid} = 2'h0;
        chk(read_data, h3);
        boot_sel_pin = ~boot_exp;
        shuffle();
        cyc(4);
        chk(boot_rom_cfg, boot_exp);
        chk_sd();
        $display("reset done");
        wr(rnd() & 32'hffff_fffe);
        wr(rnd() | 32'h0000_0001);
        cfg_wr_valid = 1'h0;
        for (int i = 0; i < 6; i++) begin
            cyc(3);
            chk_run();
            shuffle();
        end
        $display("enable done");
        for (int m = 0; m < 5; m++) begin
            lp(5'h01 << m);
            cyc(1);
            chk_idle();
            chk(static_chip_select_n[0], 1'h1);
            lp(5'h00);
            cyc(3);
            chk_run();
            shuffle();
        end
        $display("low power done");
        func_clock_enable = 1'h1;
        sdram_in_self_refresh = 1'h1;
        cyc(1);
        chk(sdram_clock_enable, 1'h0);
        sdram_in_self_refresh = 1'h0;
        cyc(2);
        chk(sdram_clock_enable, 1'h1);
        {func_oe_n, func_data_oe} = 2'h0;
        cyc(4);
        rom_rd_valid = 1'h1;
        cyc(1);
        chk(read_data, h3);
        func_address = 26'(rnd());
        cyc(1);
        chk(read_data, h3);
        rom_rd_valid = 1'h0;
        $display("refresh and rom done");
        resetn = 1'h0;
        boot_exp = ~boot_exp;
        boot_sel_pin = boot_exp;
        cyc(3);
        chk_idle();
        chk(sdram_enabled, 1'h0);
        resetn = 1'h1;
        cyc(3);
        chk(boot_rom_cfg, boot_exp);
        chk_sd();
        $display("second reset done");
        give_verdict();
    end
endmodule

`default_nettype wire
